// ### rtl/flash_seq_defines.svh
// Constants for the flash erase command sequencer host controller.
// Assumes a byte-wide flash on a parallel bus and a 10 MHz core clock.
// Summary of operation
// R01: Erase is six writes ending 10H/30H
// R02: Device pre-programs array to zeros itself
// R03: Device ends erase on margin, no verify
// R04: Timeout fail bit set on overrun
// R05: Erase done when poll 1, toggle still
// R06: Device powers up in array read
// R07: Suspended sector reads return status
// R08: Host writes reset after fail or ID
// R09: Reset returns to read, address ignored
// R10: Reset aborts erase only before start
// R11: Reset aborts program only before start
// R12: ID mode left only by reset (the model also leaves it on any unlocked command other than 90H)
// R13: Reset after timeout fail returns read
// R14: Sector erase pre-programs sectors itself
// R15: Sector erase done on poll and toggle
// R16: Address on later fall, data earlier rise
// R17: Next sector load within 50us
// R18: Erase window bit reports timer window
// R19: Other command in window returns read
// R20: Program status bit behaviour defined
// R21: Suspend read status bit behaviour defined
// R22: Host gives valid address polling status
// R23: ID read A1A0 selects maker/device code
// R24: Protect verify gives 00H or 01H
// R25: Reset data is F0H
// R26: Wrong sequence falls back to read
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH
`define ADR_CTRL        4'h0
`define ADR_ADDR        4'h4
`define ADR_DATA        4'h8
`define ADR_STATUS      4'hC
`define CTRL_GO_BIT     0
`define CTRL_OP_LSB     1
`define CMD_UNLOCK1_A   19'h0_0555
`define CMD_UNLOCK1_D   8'hAA
`define CMD_UNLOCK2_A   19'h0_02AA
`define CMD_UNLOCK2_D   8'h55
`define CMD_SETUP       8'h80
`define CMD_CHIP        8'h10
`define CMD_SECTOR      8'h30
`define CMD_RESET       8'hF0
`define CMD_ID          8'h90
`define CMD_SUSPEND     8'hB0
`define CMD_RESUME      8'h30
`define CLK_MHZ         10
`define T_WRLOW_NS      100
`define T_WRLOW_CYC     ((`T_WRLOW_NS * `CLK_MHZ + 999) / 1000)
`define T_LOAD_US       50
`define T_LOAD_CYC      ((`T_LOAD_US * `CLK_MHZ) - 2)
`endif

// ### rtl/flash_seq_pkg.sv
// Types for the flash erase command sequencer host controller.
// Assumes the defines header is included by users of the constants.
package flash_seq_pkg;
  typedef enum logic [2:0] {
    OP_READ, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_ADD_SECTOR,
    OP_RESET, OP_ID_READ, OP_SUSPEND, OP_RESUME
  } op_t;
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  data;
  } bus_word_t;
  typedef struct packed {
    logic dataPollBit;
    logic toggleBit;
    logic timeoutFailBit;
    logic eraseWindowBit;
    logic suspendToggleBit;
  } flash_status_t;
endpackage

// ### rtl/flash_erase_host.sv
// Host controller that drives the flash command pins for erase, reset,
// silicon-ID and status reads, ordered by a classic Wishbone slave.
// Assumes flash pins are synchronous to core_clk and decoded externally.
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "flash_seq_defines.svh"
module flash_erase_host (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic [3:0]  wbAdr,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [3:0]  wbSel,
  output logic             wbAck,
  output logic [18:0]      flashAddr,
  output logic [7:0]       flashDout,
  output logic             flashDoutEn_n,
  input  wire logic [7:0]  flashDin,
  output logic             flashCe_n,
  output logic             flashWe_n,
  output logic             flashOe_n,
  input  wire logic        readyBusyOutput
);
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_STROBE, S_RELEASE, S_READ, S_READEND
  } state_t;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  flash_seq_pkg::op_t        op;
  flash_seq_pkg::op_t        next_op;
  flash_seq_pkg::bus_word_t  target;
  flash_seq_pkg::bus_word_t  next_target;
  logic                      busy;
  logic                      next_busy;
  logic [7:0]                rdData;
  logic [7:0]                next_rdData;
  logic                      windowLate;
  logic                      next_windowLate;
  logic [31:0]               next_wbDatO;
  logic                      next_wbAck;

  state_t      state;
  state_t      next_state;
  logic [2:0]  step;
  logic [2:0]  next_step;
  logic [2:0]  lastStep;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [8:0]  loadCnt;
  logic [8:0]  next_loadCnt;
  flash_seq_pkg::bus_word_t  word;
  flash_seq_pkg::bus_word_t  next_word;
  logic        doRead;

  // Sequence table: cycle k of an operation
  function automatic flash_seq_pkg::bus_word_t seqWord(
      input flash_seq_pkg::op_t o, input logic [2:0] k,
      input flash_seq_pkg::bus_word_t t);
    flash_seq_pkg::bus_word_t w;
    w = '{addr: `CMD_UNLOCK1_A, data: `CMD_UNLOCK1_D};
    // R01: six-write erase
    unique case (k)
      3'd1: w = '{addr: `CMD_UNLOCK2_A, data: `CMD_UNLOCK2_D};
      3'd2: w = '{addr: `CMD_UNLOCK1_A,
                  data: (o == flash_seq_pkg::OP_ID_READ) ? `CMD_ID
                                                         : `CMD_SETUP};
      3'd3: w = '{addr: `CMD_UNLOCK1_A, data: `CMD_UNLOCK1_D};
      3'd4: w = '{addr: `CMD_UNLOCK2_A, data: `CMD_UNLOCK2_D};
      3'd5: w = (o == flash_seq_pkg::OP_CHIP_ERASE)
                ? '{addr: `CMD_UNLOCK1_A, data: `CMD_CHIP}
                : '{addr: t.addr, data: `CMD_SECTOR};
      default: w = w;
    endcase
    if (o == flash_seq_pkg::OP_ADD_SECTOR) begin
      // R17: extra sector load
      w = '{addr: t.addr, data: `CMD_SECTOR};
    end else if (o == flash_seq_pkg::OP_RESET) begin
      // R08 R25: reset code restores reads
      w = '{addr: t.addr, data: `CMD_RESET};
    end else if (o == flash_seq_pkg::OP_SUSPEND) begin
      w = '{addr: t.addr, data: `CMD_SUSPEND};
    end else if (o == flash_seq_pkg::OP_RESUME) begin
      w = '{addr: t.addr, data: `CMD_RESUME};
    end
    return w;
  endfunction

  always_comb begin
    unique case (op)
      flash_seq_pkg::OP_CHIP_ERASE,
      flash_seq_pkg::OP_SECTOR_ERASE: lastStep = 3'd5;
      flash_seq_pkg::OP_ID_READ:      lastStep = 3'd2;
      default:                        lastStep = 3'd0;
    endcase
  end

  assign doRead = (op == flash_seq_pkg::OP_READ);

  // ------------------------------------------------------------
  // Wishbone slave, one wait state
  // ------------------------------------------------------------
  logic wbHit;
  logic goWrite;
  assign wbHit   = wbCyc && wbStb && !wbAck;
  assign goWrite = wbHit && wbWe && wbSel[0] && (wbAdr == `ADR_CTRL)
                   && wbDatI[`CTRL_GO_BIT] && !busy;

  always_comb begin
    next_wbAck  = wbHit;
    next_wbDatO = 32'h0000_0000;
    next_op     = op;
    next_target = target;
    if (wbHit && !wbWe) begin
      unique case (wbAdr)
        `ADR_CTRL:   next_wbDatO = {28'h000_0000, op, 1'b0};
        `ADR_ADDR:   next_wbDatO = {13'h0000, target.addr};
        `ADR_DATA:   next_wbDatO = {24'h00_0000, rdData};
        // R18: window and device state visible
        `ADR_STATUS: next_wbDatO = {28'h000_0000, windowLate,
                                    readyBusyOutput, rdData[3], busy};
        default:     next_wbDatO = 32'h0000_0000;
      endcase
    end
    if (wbHit && wbWe && !busy) begin
      if (wbAdr == `ADR_ADDR) begin
        if (wbSel[0]) next_target.addr[7:0]   = wbDatI[7:0];
        if (wbSel[1]) next_target.addr[15:8]  = wbDatI[15:8];
        if (wbSel[2]) next_target.addr[18:16] = wbDatI[18:16];
      end
      if (goWrite) begin
        next_op = flash_seq_pkg::op_t'(wbDatI[`CTRL_OP_LSB +: 3]);
      end
    end
  end

  // ------------------------------------------------------------
  // Flash bus sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_step       = step;
    next_cnt        = cnt;
    next_word       = word;
    next_busy       = busy;
    next_rdData     = rdData;
    next_loadCnt    = (loadCnt != 9'd0) ? loadCnt - 9'd1 : 9'd0;
    next_windowLate = windowLate || (loadCnt == 9'd1);
    unique case (state)
      S_IDLE: begin
        if (goWrite) begin
          next_busy = 1'b1;
          next_step = 3'd0;
          next_cnt  = 4'd0;
          next_state = (next_op == flash_seq_pkg::OP_READ) ? S_READ
                                                           : S_SETUP;
          next_word = seqWord(next_op, 3'd0, next_target);
        end
      end
      S_SETUP: next_state = S_STROBE;
      S_STROBE: begin
        next_cnt = cnt + 4'd1;
        // R16: data held over rising edge
        if (cnt == 4'(`T_WRLOW_CYC)) begin
          next_state = S_RELEASE;
        end
      end
      S_RELEASE: begin
        next_cnt = 4'd0;
        if (step == lastStep) begin
          next_busy  = 1'b0;
          next_state = S_IDLE;
          if (word.data == `CMD_SECTOR) begin
            // R17: load window restarts
            next_loadCnt    = 9'(`T_LOAD_CYC);
            next_windowLate = 1'b0;
          end
        end else begin
          next_step  = step + 3'd1;
          next_word  = seqWord(op, step + 3'd1, target);
          next_state = S_SETUP;
        end
      end
      S_READ: begin
        next_cnt = cnt + 4'd1;
        // R05: status sampled per read
        if (cnt == 4'(`T_WRLOW_CYC)) begin
          next_rdData = flashDin;
          next_state  = S_READEND;
        end
      end
      S_READEND: begin
        next_busy  = 1'b0;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state      <= S_IDLE;
      step       <= 3'd0;
      cnt        <= 4'd0;
      word       <= '0;
      busy       <= 1'b0;
      rdData     <= 8'h00;
      loadCnt    <= 9'd0;
      windowLate <= 1'b0;
      op         <= flash_seq_pkg::OP_READ;
      target     <= '0;
      wbAck      <= 1'b0;
      wbDatO     <= 32'h0000_0000;
    end else if (clkEn) begin
      state      <= next_state;
      step       <= next_step;
      cnt        <= next_cnt;
      word       <= next_word;
      busy       <= next_busy;
      rdData     <= next_rdData;
      loadCnt    <= next_loadCnt;
      windowLate <= next_windowLate;
      op         <= next_op;
      target     <= next_target;
      wbAck      <= next_wbAck;
      wbDatO     <= next_wbDatO;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // R22: status reads use the host address
  assign flashAddr     = (state == S_READ) ? target.addr : word.addr;
  assign flashDout     = word.data;
  assign flashDoutEn_n = !(state == S_SETUP || state == S_STROBE
                           || state == S_RELEASE);
  assign flashCe_n     = !(state == S_STROBE || state == S_READ);
  assign flashWe_n     = !(state == S_STROBE);
  assign flashOe_n     = !(state == S_READ && doRead);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seqStrobe;
    !flashWe_n [*2];
  endsequence

  AST_ERASE_SIX: assert property (@(posedge core_clk) disable iff (!resetn)
    (clkEn && state == S_RELEASE && op == flash_seq_pkg::OP_CHIP_ERASE
     && step == 3'd5) |-> word.data == `CMD_CHIP) // R01
    else $error("chip erase last code wrong");
  AST_RESET_CODE: assert property (@(posedge core_clk) disable iff (!resetn)
    (state == S_STROBE && op == flash_seq_pkg::OP_RESET)
    |-> flashDout == `CMD_RESET) // R25
    else $error("reset code wrong");
  AST_WE_WIDTH: assert property (@(posedge core_clk) disable iff (!resetn)
    ($fell(flashWe_n) && clkEn) |-> seqStrobe) // R16
    else $error("write strobe too short");
  AST_DATA_HELD: assert property (@(posedge core_clk) disable iff (!resetn)
    (!flashWe_n && clkEn) |=> $stable(flashDout)) // R16
    else $error("data changed under strobe");
  AST_WINDOW: assert property (@(posedge core_clk) disable iff (!resetn)
    (clkEn && loadCnt == 9'd1) |=> windowLate) // R17
    else $error("load window not flagged");

  // ------------------------------------------------------------
  // Sequence and pin checks
  // ------------------------------------------------------------
  // R22: reads at host address
  AST_READ_ADDR: assert property (@(posedge core_clk) disable iff (!resetn)
    !flashOe_n |-> (flashAddr == target.addr && flashWe_n)) // R22
    else $error("read cycle address or strobe wrong");

  // R16: data driven under strobe
  AST_DOUT_DRIVEN: assert property (@(posedge core_clk) disable iff (!resetn)
    !flashWe_n |-> !flashDoutEn_n) // R16
    else $error("data not driven under strobe");

  // R09: reset is one write
  AST_RESET_SINGLE: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (clkEn && state == S_RELEASE && op == flash_seq_pkg::OP_RESET)
    |-> (step == 3'd0 && word.data == `CMD_RESET)) // R09
    else $error("reset write not single");

  // R01: sector code at sector address
  AST_SECTOR_LAST: assert property (@(posedge core_clk) disable iff (!resetn)
    (clkEn && state == S_RELEASE && op == flash_seq_pkg::OP_SECTOR_ERASE
     && step == 3'd5)
    |-> (word.data == `CMD_SECTOR && word.addr == target.addr)) // R01
    else $error("sector erase last write wrong");

  // R12: ID entry code
  AST_ID_ENTRY: assert property (@(posedge core_clk) disable iff (!resetn)
    (clkEn && state == S_RELEASE && op == flash_seq_pkg::OP_ID_READ
     && step == 3'd2) |-> word.data == `CMD_ID) // R12
    else $error("ID entry code wrong");

  // R17: window timer restarts
  AST_WINDOW_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    (clkEn && state == S_RELEASE && step == lastStep
     && word.data == `CMD_SECTOR)
    |=> (loadCnt == 9'(`T_LOAD_CYC) && !windowLate)) // R17
    else $error("load window not restarted");
endmodule

// ### testbench/flash_dev_model.sv
// Behavioural byte-wide flash with erase, ID and status reads.
// Assumes one host on the pins and a 1 ns time unit.
`timescale 1ns/1ns
module flash_dev_model #(
  parameter logic [7:0] MAKER    = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEVID    = 8'h4D, // Arbitrary value
  parameter int         ERASE_NS = 30000
) (
  input  wire logic        ceN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dout,
  output logic             readyBusy
);
  logic [18:0] latA;
  logic [2:0]  step = 3'h0;
  logic        idMode = 1'h0, loadWin = 1'h0, busy = 1'h0, tog = 1'h0;
  logic [7:0]  rd, last = 8'h0;
  time         tRise, tBusy;
  wire         wrN = ceN | weN;
  wire         rdN = ceN | oeN;
  always @(negedge wrN) latA = addr;
  always @(posedge wrN) begin
    tRise = $time;
    if (!busy && din == 8'hF0) begin
      step = 3'h0;
      idMode = 1'h0;
      loadWin = 1'h0;
    end
    // only 30H or B0H keep the window
    else if (!busy && loadWin)
      loadWin = din == 8'h30 || din == 8'hB0;
    else if (!busy)
      case (step)
        0, 3: step = (latA == 19'h0_0555 && din == 8'hAA) ? step + 1 : 0;
        1, 4: step = (latA == 19'h0_02AA && din == 8'h55) ? step + 1 : 0;
        2: begin
          idMode = din == 8'h90;
          step = din == 8'h80 ? 3'h3 : 3'h0;
        end
        default: begin
          busy = din == 8'h10;
          loadWin = din == 8'h30;
          tBusy = $time;
          step = 3'h0;
        end
      endcase
  end
  always #500 begin
    if (loadWin && $time - tRise > 50000) begin
      loadWin = 1'h0;
      busy = 1'h1;
      tBusy = $time;
    end
    if (busy && $time - tBusy > ERASE_NS)
      busy = 1'h0;
  end
  // read data; no overrun or suspend
  always_comb begin
    if (busy || loadWin)
      rd = {1'h0, tog, 2'h0, busy, tog, 2'h0};
    else if (idMode && addr[1])
      rd = {7'h0, addr[18]};
    else if (idMode)
      rd = addr[0] ? DEVID : MAKER;
    else
      rd = addr[7:0] ^ 8'h5A;
  end
  assign dout = rdN ? ~last : rd;
  assign readyBusy = ~busy;
  // toggle bit flips per status read
  always @(posedge rdN) begin
    last = rd;
    tog = tog ^ (busy | loadWin);
  end
endmodule

// ### testbench/flash_erase_host_test.sv
// Self-checking bench for the erase host against a flash model.
// Assumes the model erase time below and a 10 MHz core clock.
`timescale 1ns/1ns
module flash_erase_host_test;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEVID = 8'h4D; // Arbitrary value
  logic        core_clk = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
  logic [3:0]  wbAdr = 4'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO, rdv;
  logic        wbAck, ceN, weN, oeN, denN, ryBy, t;
  logic [18:0] fAddr, a;
  logic [7:0]  fOut, fIn;
  int          errTotal = 0, checks = 0;
  always #50 core_clk = ~core_clk;
  flash_erase_host u_flash_erase_host (.core_clk(core_clk), .resetn(resetn),
    .clkEn(1'h1), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(4'hF), .wbAck(wbAck),
    .flashAddr(fAddr), .flashDout(fOut), .flashDoutEn_n(denN),
    .flashDin(fIn), .flashCe_n(ceN), .flashWe_n(weN), .flashOe_n(oeN),
    .readyBusyOutput(ryBy));
  flash_dev_model #(.MAKER(MAKER), .DEVID(DEVID), .ERASE_NS(30000))
    u_flash_dev_model (.ceN(ceN), .weN(weN), .oeN(oeN), .addr(fAddr),
    .din(fOut), .dout(fIn), .readyBusy(ryBy));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [3:0] ad, input logic we,
                    input logic [31:0] d);
    int n = 0;
    wbAdr <= ad;
    wbWe <= we;
    wbDatI <= d;
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'h1 && n < 50);
    if (n >= 50)
      errTotal++;
    rdv = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic waitStat(input int b, input logic v);
    int n = 0;
    do begin
      wb(4'hC, 1'h0, 32'h0);
      n++;
    end while (rdv[b] !== v && n < 400);
    check(rdv[b], v);
  endtask
  task automatic op(input logic [2:0] o, input logic [18:0] ad);
    wb(4'h4, 1'h1, {13'h0, ad});
    wb(4'h0, 1'h1, {28'h0, o, 1'h1});
    waitStat(0, 1'h0);
  endtask
  task automatic rdf(input logic [18:0] ad, input logic [7:0] exp);
    op(3'h0, ad);
    wb(4'h8, 1'h0, 32'h0);
    check(rdv, {24'h0, exp});
  endtask
  function automatic logic [7:0] arr(input logic [18:0] ad);
    return ad[7:0] ^ 8'h5A;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    a = 19'($urandom(32'h79db_8fce));
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    wb(4'h2, 1'h0, 32'h0);
    check(rdv, 32'h0);
    repeat (4) begin
      a = 19'($urandom);
      rdf(a, arr(a));
    end
    op(3'h5, 19'h0);
    rdf(19'h0_0000, MAKER);
    rdf(19'h0_0001, DEVID);
    rdf(19'h4_0002, 8'h01);
    rdf(19'h0_0002, 8'h00);
    rdf(19'h0_0000, MAKER);
    op(3'h4, a);
    rdf(a, arr(a));
    op(3'h1, 19'h0);
    waitStat(2, 1'h0);
    op(3'h0, a);
    wb(4'h8, 1'h0, 32'h0);
    t = rdv[6];
    check(rdv & 32'h88, 32'h08);
    op(3'h4, 19'h0);
    op(3'h0, a);
    wb(4'h8, 1'h0, 32'h0);
    check(rdv[6], {31'h0, ~t});
    check(rdv & 32'h88, 32'h08);
    waitStat(2, 1'h1);
    rdf(a, arr(a));
    op(3'h2, a);
    op(3'h3, a ^ 19'h4_0000);
    op(3'h0, a);
    wb(4'h8, 1'h0, 32'h0);
    check(rdv & 32'h88, 32'h00);
    waitStat(3, 1'h1);
    waitStat(2, 1'h0);
    waitStat(2, 1'h1);
    rdf(a, arr(a));
    op(3'h2, a);
    op(3'h5, 19'h0);
    rdf(a, arr(a));
    give_verdict;
  end
  initial begin
    #3_000_000;
    errTotal++;
    give_verdict;
  end
endmodule
